// ### pmoc_defs.svh
`ifndef PMOC_DEFS_SVH
`define PMOC_DEFS_SVH

// Command codes.
`define PMOC_CMD_RUN 8'h01
`define PMOC_CMD_CFG 8'h02
`define PMOC_CMD_LEVEL 8'hfa
`define PMOC_CMD_PRIV 8'hfb
`define PMOC_CMD_PUB 8'hfc
`define PMOC_CMD_MASK 8'hfd

// Reset values.
`define PMOC_RUN_RST 8'h00
`define PMOC_CFG_RST 8'h16
`define PMOC_LEVEL_PUBLIC 8'h01
`define PMOC_PASS_RST 16'h0000
`define PMOC_MASK_RST 16'hffff

// Run-control fields.
`define PMOC_RUN_ONOFF_HI 7
`define PMOC_RUN_ONOFF_LO 6
`define PMOC_RUN_MRG_HI 5
`define PMOC_RUN_MRG_LO 4
`define PMOC_RUN_KEEP 8'hf0
`define PMOC_ONOFF_IMM 2'b00
`define PMOC_ONOFF_SOFT 2'b01
`define PMOC_ONOFF_ON 2'b10
`define PMOC_MRG_NOM 2'b00
`define PMOC_MRG_LOW 2'b01
`define PMOC_MRG_HIGH 2'b10

// Start-source configuration fields.
`define PMOC_CFG_SRC_HI 4
`define PMOC_CFG_SRC_LO 2
`define PMOC_CFG_POL 1
`define PMOC_CFG_IMM 0
`define PMOC_CFG_KEEP 8'h1f

// Write-protect mask bits, a one leaves the command writable.
`define PMOC_MASK_RUN 0
`define PMOC_MASK_CFG 1
`define PMOC_MASK_PRIV 2
`define PMOC_MASK_PUB 3

// Linear formats.
`define PMOC_FIXED_EXP 13

// Timing.
`define PMOC_CLK_NS 100
`define PMOC_SOFT_STOP_US 1000
`define PMOC_SOFT_STOP_CYC ((`PMOC_SOFT_STOP_US * 1000) / `PMOC_CLK_NS)

`endif

// ### pmoc_pkg.sv
`include "pmoc_defs.svh"

package pmoc_pkg;

   typedef enum logic [2:0] {
      PMOC_OFF = 3'b001,
      PMOC_ON = 3'b010,
      PMOC_RAMP = 3'b100
   } pmoc_state_e;

   typedef struct packed {
      pmoc_state_e state;
      logic [7:0] run;
      logic [7:0] cfg;
      logic [15:0] priv;
      logic [15:0] pub;
      logic [15:0] mask;
      logic [15:0] mask_act;
      logic [15:0] rd_data;
      logic rd_valid;
      logic cmd_err;
      logic [31:0] cnt;
      logic out_en;
      logic ramp;
      logic [1:0] margin;
   } pmoc_top_s;

   // Value of a short linear word in units of 2^-16, exponent above mantissa.
   function automatic logic signed [47:0] pmoc_short_linear(input logic [15:0] w);
      logic signed [47:0] m;
      logic signed [5:0] e;
      m = 48'(signed'(w[10:0]));
      e = 6'(signed'(w[15:11])) + 6'sd16;
      return m <<< e; // R5
   endfunction : pmoc_short_linear

   // Fixed exponent words both scale by 2^-13; returned in units of 2^-16.
   function automatic logic signed [47:0] pmoc_fixed_unsigned(input logic [15:0] w);
      return 48'({32'h0000_0000, w}) <<< (16 - `PMOC_FIXED_EXP); // R6
   endfunction : pmoc_fixed_unsigned

   function automatic logic signed [47:0] pmoc_fixed_signed(input logic [15:0] w);
      return 48'(signed'(w)) <<< (16 - `PMOC_FIXED_EXP); // R7
   endfunction : pmoc_fixed_signed

   // A passphrase carries two text characters; each must be 7-bit ASCII.
   function automatic logic pmoc_is_text(input logic [15:0] w);
      return !w[15] && !w[7]; // R8
   endfunction : pmoc_is_text

endpackage : pmoc_pkg

// ### pmoc_pin_sync.sv
`timescale 1ns/100ps
`include "pmoc_defs.svh"

// Three stages per pin; the held level moves only when stages two and three agree.
module pmoc_pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } pmoc_sync_s;

   pmoc_sync_s st_r;
   pmoc_sync_s st_nxt;

   if (WIDTH < 1) begin : g_chk
      $error("pmoc_pin_sync needs at least one pin");
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.lvl;

endmodule : pmoc_pin_sync

// ### pmoc_onoff_margin.sv
`timescale 1ns/100ps
`include "pmoc_defs.svh"

// Behaviour
// R1: Read-only access level, reads public level one.
// R2: Private passphrase readable, writable, resets zero.
// R3: Public passphrase readable, writable, resets zero.
// R4: Write-protect mask readable, writable, resets ones.
// R5: Short linear: 5-bit exponent, 11-bit mantissa.
// R6: Unsigned fixed format: mantissa times 2^-13.
// R7: Signed fixed format: mantissa times 2^-13.
// R8: Text values carried as ASCII strings.
// R9: Host disables output before most setting writes.
// R10: Every command readable at any time.
// R11: Written settings may wait until next enable.
// R12: Host waits 100ms after store or restore.
// R13: Host spaces reads 2ms, others 5ms; pmoc_host waits GAP clock cycles before every read and write.
// R14: Host stores, power cycles, re-enables to confirm.
// R15: Run bits: 00 immediate, 01 soft, 10 on.
// R16: Margin bits: 00 nominal, 01 low, 10 high.
// R17: Commanded margin only while margin pin open.
// R18: Unlisted run-control values rejected as errors.
// R19: Start source: always, pin, command, or both.
// R20: Config bit one sets enable pin polarity.
// R21: Config bit zero: pin-off ramps or immediate.
// R22: Start config resets to pin start value.
// R23: Config bits 7:5 read zero, no effect.
module pmoc_onoff_margin #(
   parameter int SOFT_STOP_CYCLES = `PMOC_SOFT_STOP_CYC
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] CMD_CODE_IN,
   input wire logic WR_STB_IN,
   input wire logic [15:0] WR_DATA_IN,
   input wire logic RD_STB_IN,
   output logic [15:0] RD_DATA_OUT,
   output logic RD_VALID_OUT,
   output logic CMD_ERR_OUT,
   input wire logic EN_PIN_IN,
   input wire logic MARGIN_PIN_OPEN_IN,
   output logic OUTPUT_EN_OUT,
   output logic RAMP_DOWN_OUT,
   output logic [1:0] MARGIN_SEL_OUT
);

   pmoc_pkg::pmoc_top_s st_r;
   pmoc_pkg::pmoc_top_s st_nxt;
   logic [1:0] pins_sync;
   logic en_pin_sync;
   logic margin_open_sync;
   logic pin_active;
   logic cmd_on;
   logic [2:0] src;
   logic want_on;
   logic stop_now;

   if (SOFT_STOP_CYCLES < 1) begin : g_chk
      $error("SOFT_STOP_CYCLES must be at least one");
   end

   pmoc_pin_sync #(
      .WIDTH(2)
   ) u_pins (
      .clock_in(CLOCK_IN),
      .rst_in(RST_IN),
      .pin_in({MARGIN_PIN_OPEN_IN, EN_PIN_IN}),
      .level_out(pins_sync)
   );

   assign en_pin_sync = pins_sync[0];
   assign margin_open_sync = pins_sync[1];

   function automatic logic run_value_ok(input logic [7:0] v);
      logic [3:0] top;
      top = v[7:4];
      return (top == 4'h0) || (top == 4'h4) || (top == 4'h8) || (top == 4'h9) || (top == 4'ha); // R18
   endfunction : run_value_ok

   always_comb begin
      pin_active = st_r.cfg[`PMOC_CFG_POL] ? en_pin_sync : !en_pin_sync; // R20
      cmd_on = st_r.run[`PMOC_RUN_ONOFF_HI:`PMOC_RUN_ONOFF_LO] == `PMOC_ONOFF_ON; // R15
      src = st_r.cfg[`PMOC_CFG_SRC_HI:`PMOC_CFG_SRC_LO];
      // Bit 2 of the source selects gated start, bit 0 the pin and bit 1 the command.
      want_on = !src[2] || ((!src[0] || pin_active) && (!src[1] || cmd_on)); // R19
      // An immediate stop from either source wins over a soft one.
      stop_now = (src[2] && src[1] &&
                  st_r.run[`PMOC_RUN_ONOFF_HI:`PMOC_RUN_ONOFF_LO] == `PMOC_ONOFF_IMM) || // R15
                 (src[2] && src[0] && !pin_active && st_r.cfg[`PMOC_CFG_IMM]); // R21
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      st_nxt.cmd_err = 1'b0;

      // Reads are never blocked by the output state.
      if (RD_STB_IN) begin
         st_nxt.rd_valid = 1'b1; // R10
         if (CMD_CODE_IN == `PMOC_CMD_RUN) begin
            st_nxt.rd_data = {8'h00, st_r.run};
         end else if (CMD_CODE_IN == `PMOC_CMD_CFG) begin
            st_nxt.rd_data = {8'h00, st_r.cfg}; // R23
         end else if (CMD_CODE_IN == `PMOC_CMD_LEVEL) begin
            st_nxt.rd_data = {8'h00, `PMOC_LEVEL_PUBLIC}; // R1
         end else if (CMD_CODE_IN == `PMOC_CMD_PRIV) begin
            st_nxt.rd_data = st_r.priv; // R2
         end else if (CMD_CODE_IN == `PMOC_CMD_PUB) begin
            st_nxt.rd_data = st_r.pub; // R3
         end else if (CMD_CODE_IN == `PMOC_CMD_MASK) begin
            st_nxt.rd_data = st_r.mask; // R4
         end else begin
            st_nxt.rd_data = 16'h0000;
            st_nxt.cmd_err = 1'b1;
         end
      end

      if (WR_STB_IN) begin
         if (CMD_CODE_IN == `PMOC_CMD_RUN) begin
            if (!st_r.mask_act[`PMOC_MASK_RUN] || !run_value_ok(WR_DATA_IN[7:0])) begin
               st_nxt.cmd_err = 1'b1; // R18
            end else begin
               st_nxt.run = WR_DATA_IN[7:0] & `PMOC_RUN_KEEP;
            end
         end else if (CMD_CODE_IN == `PMOC_CMD_CFG) begin
            if (!st_r.mask_act[`PMOC_MASK_CFG]) begin
               st_nxt.cmd_err = 1'b1;
            end else begin
               st_nxt.cfg = WR_DATA_IN[7:0] & `PMOC_CFG_KEEP; // R23
            end
         end else if (CMD_CODE_IN == `PMOC_CMD_PRIV) begin
            if (!st_r.mask_act[`PMOC_MASK_PRIV] || !pmoc_pkg::pmoc_is_text(WR_DATA_IN)) begin
               st_nxt.cmd_err = 1'b1;
            end else begin
               st_nxt.priv = WR_DATA_IN; // R2
            end
         end else if (CMD_CODE_IN == `PMOC_CMD_PUB) begin
            if (!st_r.mask_act[`PMOC_MASK_PUB] || !pmoc_pkg::pmoc_is_text(WR_DATA_IN)) begin
               st_nxt.cmd_err = 1'b1;
            end else begin
               st_nxt.pub = WR_DATA_IN; // R3
            end
         end else if (CMD_CODE_IN == `PMOC_CMD_MASK) begin
            st_nxt.mask = WR_DATA_IN; // R4
         end else begin
            // The access level is read only; writing it is refused like an unknown code.
            st_nxt.cmd_err = 1'b1; // R1
         end
      end

      // A new mask is held pending while the output runs and applied once it is off.
      if (st_r.state == pmoc_pkg::PMOC_OFF) begin
         st_nxt.mask_act = st_r.mask; // R11
      end

      case (st_r.state)
         pmoc_pkg::PMOC_OFF: begin
            st_nxt.cnt = 32'h0000_0000;
            if (want_on) begin
               st_nxt.state = pmoc_pkg::PMOC_ON; // R19
            end
         end
         pmoc_pkg::PMOC_ON: begin
            st_nxt.cnt = 32'h0000_0000;
            if (!want_on) begin
               st_nxt.state = stop_now ? pmoc_pkg::PMOC_OFF : pmoc_pkg::PMOC_RAMP; // R21
            end
         end
         pmoc_pkg::PMOC_RAMP: begin
            if (want_on) begin
               st_nxt.state = pmoc_pkg::PMOC_ON;
            end else if (stop_now || st_r.cnt == 32'(SOFT_STOP_CYCLES - 1)) begin
               st_nxt.state = pmoc_pkg::PMOC_OFF; // R15
            end else begin
               st_nxt.cnt = st_r.cnt + 32'h0000_0001;
            end
         end
         default: begin
            st_nxt.state = pmoc_pkg::PMOC_OFF;
         end
      endcase

      st_nxt.out_en = st_nxt.state == pmoc_pkg::PMOC_ON;
      st_nxt.ramp = st_nxt.state == pmoc_pkg::PMOC_RAMP;
      // A strapped margin pin overrides the commanded margin, so it must read open.
      if (st_nxt.out_en && margin_open_sync &&
          st_nxt.run[`PMOC_RUN_ONOFF_HI:`PMOC_RUN_ONOFF_LO] == `PMOC_ONOFF_ON) begin
         st_nxt.margin = st_nxt.run[`PMOC_RUN_MRG_HI:`PMOC_RUN_MRG_LO]; // R16 R17
      end else begin
         st_nxt.margin = `PMOC_MRG_NOM; // R17
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         st_r.state <= pmoc_pkg::PMOC_OFF;
         st_r.run <= `PMOC_RUN_RST;
         st_r.cfg <= `PMOC_CFG_RST; // R22
         st_r.priv <= `PMOC_PASS_RST; // R2
         st_r.pub <= `PMOC_PASS_RST; // R3
         st_r.mask <= `PMOC_MASK_RST; // R4
         st_r.mask_act <= `PMOC_MASK_RST;
         st_r.rd_data <= 16'h0000;
         st_r.rd_valid <= 1'b0;
         st_r.cmd_err <= 1'b0;
         st_r.cnt <= 32'h0000_0000;
         st_r.out_en <= 1'b0;
         st_r.ramp <= 1'b0;
         st_r.margin <= `PMOC_MRG_NOM;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RD_DATA_OUT = st_r.rd_data;
   assign RD_VALID_OUT = st_r.rd_valid;
   assign CMD_ERR_OUT = st_r.cmd_err;
   assign OUTPUT_EN_OUT = st_r.out_en;
   assign RAMP_DOWN_OUT = st_r.ramp;
   assign MARGIN_SEL_OUT = st_r.margin;

   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (RST_IN);

   sequence s_read(logic [7:0] code);
      RD_STB_IN && CMD_CODE_IN == code;
   endsequence

   sequence s_run_write_ok;
      WR_STB_IN && !RD_STB_IN && CMD_CODE_IN == `PMOC_CMD_RUN &&
         st_r.mask_act[`PMOC_MASK_RUN] && run_value_ok(WR_DATA_IN[7:0]);
   endsequence

   property p_level_public;
      s_read(`PMOC_CMD_LEVEL) |=> RD_VALID_OUT && RD_DATA_OUT == 16'h0001;
   endproperty
   a_level_public: assert property (p_level_public) else $error("access level not public"); // R1

   sequence s_priv_write_ok;
      WR_STB_IN && CMD_CODE_IN == `PMOC_CMD_PRIV && st_r.mask_act[`PMOC_MASK_PRIV] &&
         pmoc_pkg::pmoc_is_text(WR_DATA_IN);
   endsequence

   sequence s_pub_write_ok;
      WR_STB_IN && CMD_CODE_IN == `PMOC_CMD_PUB && st_r.mask_act[`PMOC_MASK_PUB] &&
         pmoc_pkg::pmoc_is_text(WR_DATA_IN);
   endsequence

   property p_priv_store;
      s_priv_write_ok |=> st_r.priv == $past(WR_DATA_IN);
   endproperty
   a_priv_store: assert property (p_priv_store) else $error("private passphrase lost"); // R2

   property p_priv_read;
      s_read(`PMOC_CMD_PRIV) |=> RD_DATA_OUT == $past(st_r.priv);
   endproperty
   a_priv_read: assert property (p_priv_read) else $error("private passphrase read wrong"); // R2

   property p_mask_store;
      WR_STB_IN && CMD_CODE_IN == `PMOC_CMD_MASK |=> st_r.mask == $past(WR_DATA_IN) && !CMD_ERR_OUT;
   endproperty
   a_mask_store: assert property (p_mask_store) else $error("mask write refused"); // R4

   property p_read_always;
      RD_STB_IN |=> RD_VALID_OUT;
   endproperty
   a_read_always: assert property (p_read_always) else $error("read went unanswered"); // R10

   property p_imm_off;
      s_run_write_ok ##0 (WR_DATA_IN[7:6] == `PMOC_ONOFF_IMM &&
         st_r.cfg[`PMOC_CFG_SRC_HI:`PMOC_CFG_SRC_LO] == 3'b110) |-> ##2 !OUTPUT_EN_OUT && !RAMP_DOWN_OUT;
   endproperty
   a_imm_off: assert property (p_imm_off) else $error("immediate off not taken"); // R15

   property p_margin_pin;
      MARGIN_SEL_OUT != `PMOC_MRG_NOM |-> $past(margin_open_sync) && OUTPUT_EN_OUT;
   endproperty
   a_margin_pin: assert property (p_margin_pin) else $error("margin applied with pin strapped"); // R17

   property p_bad_run;
      WR_STB_IN && !RD_STB_IN && CMD_CODE_IN == `PMOC_CMD_RUN && !run_value_ok(WR_DATA_IN[7:0])
         |=> CMD_ERR_OUT && $stable(st_r.run);
   endproperty
   a_bad_run: assert property (p_bad_run) else $error("bad run value accepted"); // R18

   property p_cmd_start;
      (st_r.cfg[`PMOC_CFG_SRC_HI:`PMOC_CFG_SRC_LO] == 3'b110 && cmd_on) [*2] |-> OUTPUT_EN_OUT;
   endproperty
   a_cmd_start: assert property (p_cmd_start) else $error("command start missed"); // R19

   property p_cfg_unused;
      st_r.cfg[7:5] == 3'b000;
   endproperty
   a_cfg_unused: assert property (p_cfg_unused) else $error("unused config bits set"); // R23

   property p_pub_store;
      s_pub_write_ok |=> st_r.pub == $past(WR_DATA_IN);
   endproperty
   a_pub_store: assert property (p_pub_store) else $error("public passphrase lost"); // R3

   property p_text_only;
      WR_STB_IN && (CMD_CODE_IN == `PMOC_CMD_PRIV || CMD_CODE_IN == `PMOC_CMD_PUB) &&
         (WR_DATA_IN[15] || WR_DATA_IN[7]) |=> CMD_ERR_OUT && $stable(st_r.priv) && $stable(st_r.pub);
   endproperty
   a_text_only: assert property (p_text_only) else $error("non text passphrase accepted"); // R8

   property p_level_ro;
      WR_STB_IN && CMD_CODE_IN == `PMOC_CMD_LEVEL |=> CMD_ERR_OUT;
   endproperty
   a_level_ro: assert property (p_level_ro) else $error("access level write not refused"); // R1

   property p_mask_pending;
      st_r.state != pmoc_pkg::PMOC_OFF |=> $stable(st_r.mask_act);
   endproperty
   a_mask_pending: assert property (p_mask_pending) else $error("mask applied while running"); // R11

   sequence s_ramp_last;
      RAMP_DOWN_OUT && st_r.cnt == 32'(SOFT_STOP_CYCLES - 1) && !want_on;
   endsequence

   property p_ramp_end;
      s_ramp_last |=> !RAMP_DOWN_OUT && !OUTPUT_EN_OUT;
   endproperty
   a_ramp_end: assert property (p_ramp_end) else $error("soft stop did not end"); // R15

   property p_ramp_bound;
      RAMP_DOWN_OUT |-> st_r.cnt < 32'(SOFT_STOP_CYCLES);
   endproperty
   a_ramp_bound: assert property (p_ramp_bound) else $error("soft stop ran too long"); // R21

   property p_always_on;
      st_r.cfg[`PMOC_CFG_SRC_HI:`PMOC_CFG_SRC_LO] == 3'b000 |=> OUTPUT_EN_OUT;
   endproperty
   a_always_on: assert property (p_always_on) else $error("always on source not running"); // R19

   property p_pin_imm_off;
      OUTPUT_EN_OUT && !pin_active && st_r.cfg[`PMOC_CFG_SRC_HI] && st_r.cfg[`PMOC_CFG_SRC_LO] &&
         st_r.cfg[`PMOC_CFG_IMM] |=> !OUTPUT_EN_OUT && !RAMP_DOWN_OUT;
   endproperty
   a_pin_imm_off: assert property (p_pin_imm_off) else $error("pin off not immediate"); // R21

   property p_run_low_clear;
      st_r.run[3:0] == 4'h0;
   endproperty
   a_run_low_clear: assert property (p_run_low_clear) else $error("unused run bits kept"); // R15

endmodule : pmoc_onoff_margin

// ### pmoc_host.sv
`timescale 1ns/100ps

// Host side of the command port; the caller spaces its requests through GAP.
module pmoc_host #(
   parameter int GAP = 2
) (
   input wire logic clock_in,
   output logic [7:0] cmd_code_out,
   output logic wr_stb_out,
   output logic [15:0] wr_data_out,
   output logic rd_stb_out,
   input wire logic [15:0] rd_data_in,
   input wire logic rd_valid_in,
   input wire logic cmd_err_in
);
   // No store, restore or power cycle is ever sent, so the host never owes their settle times.
   initial begin
      cmd_code_out = 8'h00;
      wr_stb_out = 1'b0;
      wr_data_out = 16'h0000;
      rd_stb_out = 1'b0;
   end

   // Released lines show the inverse so a stale value is never mistaken for a live one.
   task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic e);
      repeat (GAP) @(posedge clock_in);
      cmd_code_out <= c;
      wr_data_out <= d;
      wr_stb_out <= 1'b1;
      @(posedge clock_in);
      wr_stb_out <= 1'b0;
      cmd_code_out <= ~c;
      wr_data_out <= ~d;
      @(negedge clock_in);
      e = cmd_err_in;
   endtask : wr

   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v, output logic e);
      repeat (GAP) @(posedge clock_in);
      cmd_code_out <= c;
      rd_stb_out <= 1'b1;
      @(posedge clock_in);
      rd_stb_out <= 1'b0;
      cmd_code_out <= ~c;
      @(negedge clock_in);
      d = rd_data_in;
      v = rd_valid_in;
      e = cmd_err_in;
   endtask : rd
endmodule : pmoc_host

// ### pmoc_onoff_margin_test.sv
`timescale 1ns/100ps

module pmoc_onoff_margin_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en_pin = 1'b0;
   logic mgn_open = 1'b1;
   logic [7:0] cmd;
   logic wr_stb;
   logic [15:0] wr_data;
   logic rd_stb;
   logic [15:0] rd_data;
   logic rd_valid;
   logic cmd_err;
   logic out_en;
   logic ramp;
   logic [1:0] mgn_sel;
   int fail_count = 0;
   int n_tests = 0;
   logic [47:0] lin;

   always #50 clk = ~clk;

   pmoc_onoff_margin #(.SOFT_STOP_CYCLES(4)) u_pmoc_onoff_margin (
      .CLOCK_IN(clk), .RST_IN(rst), .CMD_CODE_IN(cmd), .WR_STB_IN(wr_stb), .WR_DATA_IN(wr_data),
      .RD_STB_IN(rd_stb), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .CMD_ERR_OUT(cmd_err),
      .EN_PIN_IN(en_pin), .MARGIN_PIN_OPEN_IN(mgn_open), .OUTPUT_EN_OUT(out_en),
      .RAMP_DOWN_OUT(ramp), .MARGIN_SEL_OUT(mgn_sel)
   );

   pmoc_host #(.GAP(2)) u_pmoc_host (
      .clock_in(clk), .cmd_code_out(cmd), .wr_stb_out(wr_stb), .wr_data_out(wr_data),
      .rd_stb_out(rd_stb), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .cmd_err_in(cmd_err)
   );

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("mismatches %0d of %0d comparisons", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic twr(input logic [7:0] c, input logic [15:0] d, input logic exp_err);
      logic e;
      u_pmoc_host.wr(c, d, e);
      check({15'h0000, e}, {15'h0000, exp_err}, "write error flag");
   endtask : twr

   task automatic trd(input logic [7:0] c, input logic [15:0] exp, input logic exp_err);
      logic [15:0] d;
      logic v;
      logic e;
      u_pmoc_host.rd(c, d, v, e);
      check(d, exp, "read data");
      check({15'h0000, e}, {15'h0000, exp_err}, "read error flag");
      if (!exp_err) check({15'h0000, v}, 16'h0001, "read valid");
   endtask : trd

   // Waits a bounded time for the output state, noting whether a soft stop was seen.
   task automatic wait_out(input logic exp, input logic exp_ramp);
      logic seen_ramp;
      int i;
      seen_ramp = 1'b0;
      for (i = 0; i < 30 && out_en !== exp; i++) begin
         @(negedge clk);
         seen_ramp |= ramp;
      end
      check({15'h0000, out_en}, {15'h0000, exp}, "output enable");
      check({15'h0000, seen_ramp}, {15'h0000, exp_ramp}, "soft stop seen");
   endtask : wait_out

   task automatic set_pins(input logic en, input logic open);
      @(posedge clk);
      en_pin <= en;
      mgn_open <= open;
      @(negedge clk);
   endtask : set_pins

   initial begin
      #(100 * 20000);
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      stop_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      trd(8'h01, 16'h0000, 1'b0);
      trd(8'h02, 16'h0016, 1'b0);
      trd(8'hfa, 16'h0001, 1'b0);
      trd(8'hfb, 16'h0000, 1'b0);
      trd(8'hfc, 16'h0000, 1'b0);
      trd(8'hfd, 16'hffff, 1'b0);
      trd(8'h55, 16'h0000, 1'b1);
      lin = pmoc_pkg::pmoc_short_linear(16'hba00);
      check(lin[31:16], 16'h0001, "short linear one");
      lin = pmoc_pkg::pmoc_fixed_unsigned(16'h2000);
      check(lin[31:16], 16'h0001, "unsigned fixed one");
      lin = pmoc_pkg::pmoc_fixed_signed(16'he000);
      check(lin[31:16], 16'hffff, "signed fixed minus one");
      twr(8'hfa, 16'h0002, 1'b1);
      trd(8'hfa, 16'h0001, 1'b0);
      twr(8'hfb, 16'h4142, 1'b0);
      twr(8'hfc, 16'h4344, 1'b0);
      twr(8'hfb, 16'h8041, 1'b1);
      trd(8'hfb, 16'h4142, 1'b0);
      trd(8'hfc, 16'h4344, 1'b0);
      // The output is off here, so the new mask is in force at once.
      twr(8'hfd, 16'hfffd, 1'b0);
      trd(8'hfd, 16'hfffd, 1'b0);
      twr(8'h02, 16'h0017, 1'b1);
      twr(8'hfd, 16'hffff, 1'b0);
      twr(8'h02, 16'h00fe, 1'b0);
      trd(8'h02, 16'h001e, 1'b0);
      twr(8'h01, 16'h0080, 1'b0);
      repeat (10) @(negedge clk);
      wait_out(1'b0, 1'b0);
      set_pins(1'b1, 1'b1);
      wait_out(1'b1, 1'b0);
      set_pins(1'b0, 1'b1);
      wait_out(1'b0, 1'b1);
      twr(8'h02, 16'h001a, 1'b0);
      wait_out(1'b1, 1'b0);
      trd(8'h01, 16'h0080, 1'b0);
      twr(8'hfd, 16'hfffe, 1'b0);
      twr(8'h01, 16'h008f, 1'b0);
      trd(8'h01, 16'h0080, 1'b0);
      twr(8'h01, 16'h0090, 1'b0);
      check({14'h0000, mgn_sel}, 16'h0001, "margin low");
      twr(8'h01, 16'h00a0, 1'b0);
      check({14'h0000, mgn_sel}, 16'h0002, "margin high");
      set_pins(1'b0, 1'b0);
      repeat (8) @(negedge clk);
      check({14'h0000, mgn_sel}, 16'h0000, "margin pin strapped");
      set_pins(1'b0, 1'b1);
      twr(8'h01, 16'h00b0, 1'b1);
      twr(8'h01, 16'h00c0, 1'b1);
      trd(8'h01, 16'h00a0, 1'b0);
      twr(8'h01, 16'h0040, 1'b0);
      wait_out(1'b0, 1'b1);
      repeat (3) @(negedge clk);
      check({15'h0000, ramp}, 16'h0001, "soft stop still running");
      @(negedge clk);
      check({15'h0000, ramp}, 16'h0000, "soft stop ended");
      twr(8'h01, 16'h0080, 1'b1);
      twr(8'hfd, 16'hffff, 1'b0);
      twr(8'h01, 16'h0080, 1'b0);
      wait_out(1'b1, 1'b0);
      check({14'h0000, mgn_sel}, 16'h0000, "margin nominal");
      twr(8'h01, 16'h0000, 1'b0);
      wait_out(1'b0, 1'b0);
      twr(8'h02, 16'h0017, 1'b0);
      set_pins(1'b1, 1'b1);
      wait_out(1'b1, 1'b0);
      set_pins(1'b0, 1'b1);
      wait_out(1'b0, 1'b0);
      twr(8'h02, 16'h0016, 1'b0);
      set_pins(1'b1, 1'b1);
      wait_out(1'b1, 1'b0);
      set_pins(1'b0, 1'b1);
      wait_out(1'b0, 1'b1);
      twr(8'h02, 16'h0014, 1'b0);
      wait_out(1'b1, 1'b0);
      set_pins(1'b1, 1'b1);
      wait_out(1'b0, 1'b1);
      twr(8'h02, 16'h0000, 1'b0);
      wait_out(1'b1, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({15'h0000, out_en}, 16'h0000, "output off after reset");
      trd(8'h02, 16'h0016, 1'b0);
      trd(8'hfb, 16'h0000, 1'b0);
      stop_test();
   end
endmodule : pmoc_onoff_margin_test
